// >>> col_output_logic.sv
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module col_output_logic
  import col_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic [7:0]             regAddr,
  input  wire logic [31:0]            regWdata,
  input  wire logic                   regWrite,
  input  wire logic                   regRead,
  output logic      [31:0]            regRdata,
  input  wire logic [NUM_SIGNALS-1:0] relaySignals,
  input  wire logic [NUM_OUTPUTS-1:0] defaultFunction,
  input  wire logic                   otherTripCause,
  output logic      [NUM_OUTPUTS-1:0] outputCoil,
  output logic                        tripBus,
  output logic                        configurableTripType,
  output logic                        irq
);
  import col_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [NUM_OUTPUTS-1:0][MODE_W-1:0]              mode;
    logic [NUM_OUTPUTS-1:0][NUM_GATE_IN*SEL_W-1:0]   sel;
    logic [DELAY_W-1:0]                              pickupMs;
    logic [DELAY_W-1:0]                              dropoutMs;
    logic [15:0]                                     tickCnt;
    logic                                            tick;
    logic [NUM_OUTPUTS-1:0]                          coil;
    logic                                            trip;
    logic                                            ctbType;
    logic                                            tripPrev;
    logic [IRQ_W-1:0]                                irqStatus;
    logic [IRQ_W-1:0]                                irqMask;
    logic                                            irqOut;
    logic [31:0]                                     rdata;
  } col_state_s;

  col_state_s s_q, s_d;

  logic [NUM_OUTPUTS-1:0] gateOut;
  logic                   timedOverload;
  logic [DELAY_W-1:0]     dropEff;
  logic [MODE_W-1:0]      ovlMode;
  logic                   ovlTripMode;

  // ****************************************************************
  // gates per output
  // ****************************************************************
  for (genvar o = 0; o < NUM_OUTPUTS; o++)
  begin : g_out
    col_gate u_gate (
      .signals (relaySignals),
      .selects (s_q.sel[o]),
      .useAnd  (s_q.mode[o] == MODE_AND || s_q.mode[o] == MODE_AND_TRIP),
      .gateOut (gateOut[o])
    );
  end

  assign ovlMode     = s_q.mode[OVERLOAD_INDEX];
  assign ovlTripMode = (ovlMode == MODE_OR_TRIP) || (ovlMode == MODE_AND_TRIP);
  // trip modes override the programmed dropout
  assign dropEff     = ovlTripMode ? DELAY_W'(FIXED_DROP_MS) : s_q.dropoutMs;

  // timer sits only on the overload output
  col_timer u_timer (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .tick      (s_q.tick),
    .gateIn    (gateOut[OVERLOAD_INDEX] && ovlMode != MODE_DEFAULT),
    .pickupMs  (s_q.pickupMs),
    .dropoutMs (dropEff),
    .timedOut  (timedOverload)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [IRQ_W-1:0] events;
    logic             tripNext;
    logic [2:0]       wmode;
    events   = '0;
    tripNext = 1'b0;
    wmode    = regWdata[2:0];
    s_d      = s_q;
    s_d.rdata = '0;

    // millisecond tick
    if (s_q.tickCnt == 16'(TICK_CYCLES - 1))
    begin
      s_d.tickCnt = '0;
      s_d.tick    = 1'b1;
    end
    else
    begin
      s_d.tickCnt = s_q.tickCnt + 16'h0001;
      s_d.tick    = 1'b0;
    end

    // plain outputs
    for (int o = 0; o < NUM_OUTPUTS; o++)
    begin
      if (o != OVERLOAD_INDEX)
      begin
        if (s_q.mode[o] == MODE_DEFAULT)
          s_d.coil[o] = defaultFunction[o];
        else
          s_d.coil[o] = gateOut[o];
      end
    end

    // overload output and trip bus
    if (ovlMode == MODE_DEFAULT)
      s_d.coil[OVERLOAD_INDEX] = defaultFunction[OVERLOAD_INDEX];
    else
      s_d.coil[OVERLOAD_INDEX] = timedOverload;
    tripNext = ovlTripMode && timedOverload;
    s_d.trip = tripNext;

    // trip type latches on the rising edge of a gate-caused trip
    if (tripNext && !s_q.trip)
      s_d.ctbType = !otherTripCause;
    else if (!tripNext)
      s_d.ctbType = 1'b0;
    s_d.tripPrev = s_q.trip;

    // events: trip start, overload coil on, gate-caused trip
    events[0] = tripNext && !s_q.trip;
    events[1] = s_d.coil[OVERLOAD_INDEX] && !s_q.coil[OVERLOAD_INDEX];
    events[2] = s_d.ctbType && !s_q.ctbType;

    // register writes; set wins over clear
    if (regWrite)
    begin
      if (regAddr < ADDR_SEL_BASE && regAddr[1:0] == 2'b00
          && regAddr[7:2] < 6'(NUM_OUTPUTS))
      begin
        // reject modes the output cannot serve
        if (regAddr[7:2] == 6'(OVERLOAD_INDEX))
        begin
          if (wmode <= MODE_AND_TRIP)
            s_d.mode[regAddr[4:2]] = wmode;
        end
        else if (wmode <= MODE_AND)
          s_d.mode[regAddr[4:2]] = wmode;
      end
      else if (regAddr >= ADDR_SEL_BASE && regAddr < ADDR_PICKUP
               && regAddr[1:0] == 2'b00)
      begin
        // two words per output, four 7-bit selectors in the low 28 bits of each
        if (regAddr[2] == 1'b0)
          s_d.sel[3'((regAddr - ADDR_SEL_BASE) >> 3)][27:0] = regWdata[27:0];
        else
          s_d.sel[3'((regAddr - ADDR_SEL_BASE) >> 3)][55:28] = regWdata[27:0];
      end
      else if (regAddr == ADDR_PICKUP)
        s_d.pickupMs = regWdata[15:0];
      else if (regAddr == ADDR_DROPOUT)
        s_d.dropoutMs = regWdata[15:0];
      else if (regAddr == ADDR_IRQ_STATUS)
        s_d.irqStatus = s_q.irqStatus & ~regWdata[IRQ_W-1:0];
      else if (regAddr == ADDR_IRQ_MASK)
        s_d.irqMask = regWdata[IRQ_W-1:0];
    end
    s_d.irqStatus = s_d.irqStatus | events;
    s_d.irqOut    = |(s_d.irqStatus & s_d.irqMask);

    // register reads, unmapped reads return zero
    if (regRead)
    begin
      if (regAddr < ADDR_SEL_BASE && regAddr[1:0] == 2'b00
          && regAddr[7:2] < 6'(NUM_OUTPUTS))
        s_d.rdata = {29'h0, s_q.mode[regAddr[4:2]]};
      else if (regAddr >= ADDR_SEL_BASE && regAddr < ADDR_PICKUP
               && regAddr[1:0] == 2'b00)
      begin
        if (regAddr[2] == 1'b0)
          s_d.rdata = {4'h0, s_q.sel[3'((regAddr - ADDR_SEL_BASE) >> 3)][27:0]};
        else
          s_d.rdata = {4'h0, s_q.sel[3'((regAddr - ADDR_SEL_BASE) >> 3)][55:28]};
      end
      else if (regAddr == ADDR_PICKUP)
        s_d.rdata = {16'h0, s_q.pickupMs};
      else if (regAddr == ADDR_DROPOUT)
        s_d.rdata = {16'h0, s_q.dropoutMs};
      else if (regAddr == ADDR_STATUS)
        s_d.rdata = {22'h0, s_q.ctbType, s_q.trip, 2'h0, s_q.coil};
      else if (regAddr == ADDR_IRQ_STATUS)
        s_d.rdata = {29'h0, s_q.irqStatus};
      else if (regAddr == ADDR_IRQ_MASK)
        s_d.rdata = {29'h0, s_q.irqMask};
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      s_q           <= '0;
      s_q.pickupMs  <= PICKUP_RESET;
      s_q.dropoutMs <= DROPOUT_RESET;
    end
    else
      s_q <= s_d;
  end

  assign regRdata             = s_q.rdata;
  assign outputCoil           = s_q.coil;
  assign tripBus              = s_q.trip;
  assign configurableTripType = s_q.ctbType;
  assign irq                  = s_q.irqOut;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence trip_rise;
    !tripBus ##1 tripBus;
  endsequence

  a_trip_mode_only: assert property (tripBus |-> $past(ovlTripMode))
    else $error("trip bus driven outside trip modes");
  a_trip_with_coil: assert property (tripBus |-> outputCoil[OVERLOAD_INDEX])
    else $error("trip without overload coil");
  a_ovl_mode_range: assert property (ovlMode <= MODE_AND_TRIP)
    else $error("overload mode out of range");
  a_plain_mode_range: assert property (s_q.mode[0] <= MODE_AND)
    else $error("plain output mode out of range");
  a_default_follow: assert property (s_q.mode[0] == MODE_DEFAULT |=>
      outputCoil[0] == $past(defaultFunction[0]))
    else $error("default function not followed");
  a_ctb_on_trip: assert property (configurableTripType |-> tripBus)
    else $error("trip type without trip");
  a_timed_coil: assert property (ovlMode != MODE_DEFAULT && !timedOverload |=>
      !outputCoil[OVERLOAD_INDEX])
    else $error("overload coil bypassed timer");
  a_ctb_rise: assert property (trip_rise |-> configurableTripType == !$past(otherTripCause))
    else $error("trip type wrong at trip start");
  a_irq_level: assert property (irq == |(s_q.irqStatus & s_q.irqMask))
    else $error("interrupt level differs from unmasked status");

  // ****************************************************************
  // register port and event checks
  // ****************************************************************
  sequence ovl_coil_rise;
    !outputCoil[OVERLOAD_INDEX] ##1 outputCoil[OVERLOAD_INDEX];
  endsequence

  // read data must not linger, software polls back to back
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside read cycle");

  a_pickup_read: assert property ($past(regRead && regAddr == ADDR_PICKUP) |->
      regRdata == {16'h0, $past(s_q.pickupMs)})
    else $error("pickup delay read back wrong");

  a_plain_modes_all: assert property (s_q.mode[1] <= MODE_AND && s_q.mode[2] <= MODE_AND
      && s_q.mode[4] <= MODE_AND && s_q.mode[5] <= MODE_AND)
    else $error("plain output holds trip mode");

  a_or_follow: assert property (s_q.mode[0] == MODE_OR |=>
      outputCoil[0] == $past(gateOut[0]))
    else $error("or gate not driving coil");

  a_and_follow: assert property (s_q.mode[5] == MODE_AND |=>
      outputCoil[5] == $past(gateOut[5]))
    else $error("and gate not driving coil");

  a_ovl_default: assert property (ovlMode == MODE_DEFAULT |=>
      outputCoil[OVERLOAD_INDEX] == $past(defaultFunction[OVERLOAD_INDEX]))
    else $error("overload default function not followed");

  // no path around the timer in any gate mode
  a_ovl_timed: assert property (ovlMode != MODE_DEFAULT |=>
      outputCoil[OVERLOAD_INDEX] == $past(timedOverload))
    else $error("overload coil not from timer");

  a_no_trip_plain: assert property (!ovlTripMode |=> !tripBus)
    else $error("trip bus driven in plain mode");

  a_trip_follow: assert property (ovlTripMode && timedOverload |=> tripBus)
    else $error("trip bus missing in trip mode");

  a_drop_fixed: assert property (ovlTripMode |-> dropEff == 16'h0019)
    else $error("trip mode dropout not fixed");

  a_ctb_hold: assert property (tripBus && $past(tripBus) |->
      $stable(configurableTripType))
    else $error("trip type changed during trip");

  a_trip_event: assert property (trip_rise |-> s_q.irqStatus[0])
    else $error("trip start not flagged");

  a_coil_event: assert property (ovl_coil_rise |-> s_q.irqStatus[1])
    else $error("overload coil rise not flagged");

  // set wins, so only a status write may drop a sticky bit
  a_irq_sticky: assert property (s_q.irqStatus[0] && !(regWrite
      && regAddr == ADDR_IRQ_STATUS) |=> s_q.irqStatus[0])
    else $error("sticky status lost");

  a_mask_quiet: assert property (s_q.irqMask == 3'h0 && !regWrite |=> !irq)
    else $error("masked interrupt raised");

  // the timer counts in ticks, one clock wide each
  a_tick_pulse: assert property (s_q.tick |=> !s_q.tick)
    else $error("tick wider than one cycle");
endmodule : col_output_logic

// >>> col_pkg.sv
package col_pkg;

  // ****************************************************************
  // output groups and modes
  // ****************************************************************
  localparam int unsigned NUM_OUTPUTS    = 6;
  localparam int unsigned NUM_GATE_IN    = 8;
  localparam int unsigned NUM_SIGNALS    = 64;
  localparam int unsigned OVERLOAD_INDEX = 3;
  localparam int unsigned SEL_W          = 7;
  localparam int unsigned MODE_W         = 3;
  localparam int unsigned DELAY_W        = 16;

  localparam logic [2:0] MODE_DEFAULT   = 3'h0;
  localparam logic [2:0] MODE_OR        = 3'h1;
  localparam logic [2:0] MODE_AND       = 3'h2;
  localparam logic [2:0] MODE_OR_TRIP   = 3'h3;
  localparam logic [2:0] MODE_AND_TRIP  = 3'h4;

  localparam logic [6:0] SEL_UNUSED     = 7'h00;
  localparam logic [6:0] SEL_MAX        = 7'h40;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_MODE_BASE   = 8'h00;
  // mode words of all six outputs sit below this, 0x00..0x14
  localparam logic [7:0] ADDR_SEL_BASE    = 8'h20;
  localparam logic [7:0] ADDR_PICKUP      = 8'h50;
  localparam logic [7:0] ADDR_DROPOUT     = 8'h54;
  localparam logic [7:0] ADDR_STATUS      = 8'h58;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h5c;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h60;
  localparam int unsigned SEL_STRIDE      = 8;

  localparam logic [15:0] PICKUP_RESET    = 16'h0000;
  localparam logic [15:0] DROPOUT_RESET   = 16'h0000;
  localparam int unsigned IRQ_W           = 3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_US / 1000;
  localparam int unsigned FIXED_DROP_MS   = 25;

  typedef enum logic [2:0] {
    COL_IDLE   = 3'b001,
    COL_PICKUP = 3'b010,
    COL_ACTIVE = 3'b100
  } col_tstate_e;

endpackage : col_pkg

// >>> col_gate.sv
`timescale 1ns/1ps
module col_gate
  import col_pkg::*;
(
  input  wire logic [NUM_SIGNALS-1:0]          signals,
  input  wire logic [NUM_GATE_IN*SEL_W-1:0]    selects,
  input  wire logic                            useAnd,
  output logic                                 gateOut
);
  import col_pkg::*;

  logic [NUM_GATE_IN-1:0] term;

  // ****************************************************************
  // eight selectable gate inputs
  // ****************************************************************
  for (genvar g = 0; g < NUM_GATE_IN; g++)
  begin : g_in
    logic [SEL_W-1:0] sel;
    assign sel = selects[g*SEL_W +: SEL_W];
    // unused or out-of-range selectors are neutral for the gate type
    always_comb
    begin
      if (sel == SEL_UNUSED || sel > SEL_MAX)
        term[g] = useAnd;
      else
        term[g] = signals[6'(sel - 7'h01)];
    end
  end

  assign gateOut = useAnd ? &term : |term;
endmodule : col_gate

// >>> col_timer.sv
`timescale 1ns/1ps
module col_timer
  import col_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               tick,
  input  wire logic               gateIn,
  input  wire logic [DELAY_W-1:0] pickupMs,
  input  wire logic [DELAY_W-1:0] dropoutMs,
  output logic                    timedOut
);
  import col_pkg::*;

  typedef struct packed {
    col_tstate_e        st;
    logic [DELAY_W-1:0] cnt;
  } col_tmr_s;

  col_tmr_s s_q, s_d;

  // ****************************************************************
  // pickup / dropout timer, millisecond ticks
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    case (s_q.st)
      COL_IDLE:
      begin
        s_d.cnt = '0;
        if (gateIn)
          s_d.st = COL_PICKUP;
      end
      COL_PICKUP:
      begin
        if (!gateIn)
        begin
          s_d.st  = COL_IDLE;
          s_d.cnt = '0;
        end
        else if (s_q.cnt >= pickupMs)
        begin
          s_d.st  = COL_ACTIVE;
          s_d.cnt = '0;
        end
        else if (tick)
          s_d.cnt = s_q.cnt + 16'h0001;
      end
      COL_ACTIVE:
      begin
        if (gateIn)
          s_d.cnt = '0;
        else if (s_q.cnt >= dropoutMs)
        begin
          s_d.st  = COL_IDLE;
          s_d.cnt = '0;
        end
        else if (tick)
          s_d.cnt = s_q.cnt + 16'h0001;
      end
      default:
      begin
        s_d.st  = COL_IDLE;
        s_d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      s_q <= '{st: COL_IDLE, cnt: '0};
    else
      s_q <= s_d;
  end

  assign timedOut = (s_q.st == COL_ACTIVE);
endmodule : col_timer

// >>> col_coil_model.sv
`timescale 1ns/1ps
// ****************************************************************
// far side: relay coils and trip bus, counts trip operations
// ****************************************************************
module col_coil_model
  import col_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic [NUM_OUTPUTS-1:0] outputCoil,
  input  wire logic                   tripBus,
  output logic      [7:0]             tripCount
);
  import col_pkg::*;

  logic tripSeen_q;

  // a trip counts once per rising edge; a held trip bus is one operation
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      tripSeen_q <= 1'b0;
      tripCount  <= 8'h00;
    end
    else
    begin
      tripSeen_q <= tripBus;
      if (tripBus && !tripSeen_q)
      begin
        tripCount <= tripCount + 8'h01;
      end
    end
  end
endmodule : col_coil_model

// >>> col_output_logic_bench.sv
`timescale 1ns/1ps
module col_output_logic_bench;
  import col_pkg::*;

  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdata;
  logic [63:0] relaySignals = 64'h0;
  logic [5:0]  defaultFunction = 6'h00;
  logic        otherTripCause = 1'b0;
  logic [5:0]  outputCoil;
  logic        tripBus;
  logic        configurableTripType;
  logic        irq;
  logic [7:0]  tripCount;
  int          mismatches = 0;
  int          n_tests = 0;

  always #20 ref_clk = ~ref_clk;

  col_output_logic u_dut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .relaySignals(relaySignals), .defaultFunction(defaultFunction),
    .otherTripCause(otherTripCause), .outputCoil(outputCoil), .tripBus(tripBus),
    .configurableTripType(configurableTripType), .irq(irq));

  col_coil_model u_coils (.ref_clk(ref_clk), .reset(reset), .outputCoil(outputCoil),
    .tripBus(tripBus), .tripCount(tripCount));

  // ****************************************************************
  // bus and compare helpers
  // ****************************************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic tick_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick_n

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(what, exp, regRdata);
  endtask : rd_chk

  // timer works in 1 ms ticks, so waits are bounded by a few ticks
  task automatic wait_ol(input logic useTrip, input logic lvl);
    int i;
    for (i = 0; i < 60000; i++)
    begin
      @(posedge ref_clk);
      #1;
      if ((useTrip ? tripBus : outputCoil[OVERLOAD_INDEX]) === lvl)
        return;
    end
    mismatches++;
    $display("MISMATCH overload wait expected %h seen timeout", lvl);
    close_out();
  endtask : wait_ol

  task automatic gate_chk(input int o, input logic [2:0] m, input logic [63:0] s,
                          input logic e);
    wr(8'(4 * o), {29'h0, m});
    relaySignals <= s;
    tick_n(3);
    #1 chk("coil", {31'h0, e}, {31'h0, outputCoil[o]});
  endtask : gate_chk

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    chk("coils at reset", 32'h0, {26'h0, outputCoil});
    rd_chk("pickup", ADDR_PICKUP, {16'h0, PICKUP_RESET});
    rd_chk("dropout", ADDR_DROPOUT, {16'h0, DROPOUT_RESET});
    rd_chk("unmapped", 8'hfc, 32'h0);
  endtask : t_reset

  task automatic t_plain();
    int o;
    for (o = 0; o < NUM_OUTPUTS; o++)
    begin
      if (o == OVERLOAD_INDEX)
        continue;
      wr(8'(ADDR_SEL_BASE + 8 * o), 32'h0000_2001);
      wr(8'(ADDR_SEL_BASE + 8 * o + 4), 32'h0);
      defaultFunction <= 6'h3f;
      gate_chk(o, MODE_DEFAULT, 64'h0, 1'b1);
      defaultFunction <= 6'h00;
      gate_chk(o, MODE_DEFAULT, 64'h0, 1'b0);
      gate_chk(o, MODE_OR, 64'h8000_0000_0000_0000, 1'b1);
      gate_chk(o, MODE_OR, 64'h0000_0000_0000_0002, 1'b0);
      gate_chk(o, MODE_AND, 64'h8000_0000_0000_0001, 1'b1);
      gate_chk(o, MODE_AND, 64'h0000_0000_0000_0001, 1'b0);
      wr(8'(4 * o), 32'h3);
      rd_chk("mode kept", 8'(4 * o), 32'h2);
    end
    chk("no trip", 32'h0, {24'h0, tripCount});
  endtask : t_plain

  task automatic t_overload();
    wr(8'(ADDR_SEL_BASE + 8 * OVERLOAD_INDEX), 32'h0000_2001);
    wr(8'(ADDR_SEL_BASE + 8 * OVERLOAD_INDEX + 4), 32'h0);
    wr(8'h0c, 32'h4);
    rd_chk("mode 4", 8'h0c, 32'h4);
    wr(8'h0c, 32'h5);
    rd_chk("mode 5 refused", 8'h0c, 32'h4);
    wr(8'h0c, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h7);
    relaySignals <= 64'h8000_0000_0000_0000;
    wait_ol(1'b0, 1'b1);
    chk("trip in mode 1", 32'h0, {31'h0, tripBus});
    relaySignals <= 64'h0;
    wait_ol(1'b0, 1'b0);
    rd_chk("irq coil on", ADDR_IRQ_STATUS, 32'h2);
    wr(ADDR_IRQ_STATUS, 32'h7);
    wr(8'h0c, 32'h3);
    relaySignals <= 64'h8000_0000_0000_0000;
    wait_ol(1'b1, 1'b1);
    tick_n(2);
    #1 chk("coil with trip", 32'h1, {31'h0, outputCoil[OVERLOAD_INDEX]});
    chk("trip type", 32'h1, {31'h0, configurableTripType});
    chk("trip count", 32'h1, {24'h0, tripCount});
    rd_chk("status", ADDR_STATUS, 32'h0000_0308);
    rd_chk("irq status", ADDR_IRQ_STATUS, 32'h7);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h7);
    tick_n(2);
    #1 chk("irq raised", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STATUS, 32'h7);
    tick_n(2);
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    // programmed dropout is 0, yet the fixed 25 ms must hold the coil
    relaySignals <= 64'h0;
    tick_n(30000);
    #1 chk("fixed dropout", 32'h1, {31'h0, outputCoil[OVERLOAD_INDEX]});
  endtask : t_overload

  initial
  begin
    tick_n(4);
    reset <= 1'b0;
    t_reset();
    t_plain();
    t_overload();
    close_out();
  end
endmodule : col_output_logic_bench
